// ==== verilog/lcd_host_pkg.sv ====
// Constants and types shared by the LCD host-port controller
package lcd_host_pkg;

  // Clock and link timing
  localparam int CLK_MHZ = 50;
  localparam int LINK_HALF_NS = 80;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] DIV_LAST = 4'(LINK_HALF_CYC - 1);

  // Register offsets
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_CMD = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [31:0] ADDR_RXDATA = 32'h0000_000C;

  // Control register fields and reset value
  localparam int CTRL_STRAP_LSB = 0;
  localparam int CTRL_RESET_REL_BIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Command register fields
  localparam int CMD_DC_BIT = 20;
  localparam int CMD_RD_BIT = 21;
  localparam int CMD_LEN_LSB = 22;
  localparam int CMD_KEEP_BIT = 24;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // Strap decode: upper pair for the serial family
  localparam logic [1:0] STRAP_SER3 = 2'h1;
  localparam logic [1:0] STRAP_SER4 = 2'h3;

  // Serial unit and read lengths, as last-bit indices
  localparam logic [5:0] SER3_LAST = 6'h08;
  localparam logic [5:0] SER4_LAST = 6'h07;
  localparam logic [5:0] RLEN8_LAST = 6'h07;
  localparam logic [5:0] RLEN24_LAST = 6'h17;
  localparam logic [5:0] RLEN32_LAST = 6'h1F;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE, PH_P_LOW, PH_P_HIGH, PH_S_LOW, PH_S_HIGH, PH_R_LOW, PH_R_HIGH
  } phase_t;

  // Pins driven toward the display driver
  typedef struct packed {
    logic [3:0] strap;
    logic reset_n;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic dc;
    logic [17:0] data_out;
    logic data_oe;
    logic sclk;
    logic sda_out;
    logic sda_oe;
  } lcd_pins_t;

  // AXI4-Lite slave outputs
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_out_t;

  // Whole controller state
  typedef struct packed {
    axi_out_t axi;
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] ctrl;
    logic [31:0] cmd;
    logic busy;
    logic done;
    logic [31:0] rx;
    logic [8:0] tx;
    logic [5:0] bitcnt;
    logic [3:0] div;
    phase_t phase;
    logic [17:0] din_s1;
    logic [17:0] din_s2;
    logic sda_s1;
    logic sda_s2;
    lcd_pins_t pins;
  } ctrl_state_t;

endpackage : lcd_host_pkg

// ==== verilog/lcd_host_ctrl.sv ====
// LCD driver host controller: AXI4-Lite registers driving the parallel or serial host port
// Functional notes
// - Four strap outputs select interface; upper 01 is 3-line, 11 is 4-line serial.
// - Select high carries data or parameter; select low carries a command code.
// - Host writes pulse write strobe low then high, read strobe high, select set.
// - Host reads pulse read strobe low; host samples data at the rising edge.
// - Serial: 3-line sends flag plus byte, 4-line sends byte with select pin.
// - Serial bytes go most significant bit first; commands in any order.
// - Chip select falls before the first serial clock edge and opens a transfer.
// - Host changes serial data on falling clock edges, bit seven first.
// - Serial read: command first, then device answers on the same line.
// - Host releases the data line by the falling edge of the command's last bit.
`timescale 1ns/100ps
module lcd_host_ctrl
  import lcd_host_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Display driver control pins
  output logic [3:0] interface_strap_pins,
  output logic external_reset_n,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic cmd_data_select,
  // Parallel data bus
  output logic [17:0] data_out,
  output logic data_oe,
  input wire logic [17:0] data_in,
  // Serial link
  output logic serial_clk,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic serial_data_in
);

  ctrl_state_t s;
  ctrl_state_t next_s;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Word to pins for the strapped parallel width and mapping
  function automatic logic [17:0] map_out(input logic [3:0] strap, input logic dc, input logic [17:0] d);
    logic [17:0] r;
    r = d;
    if (!dc) begin
      r = {10'h000, d[7:0]};
    end else begin
      case (strap)
        4'h0: r = {2'h0, d[15:0]};
        4'h1: r = {10'h000, d[7:0]};
        4'h2: r = {d[15:8], 1'b0, d[7:0], 1'b0};
        4'h3: r = {d[7:0], 10'h000};
        4'h9: r = {9'h000, d[8:0]};
        4'hB: r = {d[8:0], 9'h000};
        default: r = d;
      endcase
    end
    return r;
  endfunction : map_out

  // Pins back to a word, inverse of map_out
  function automatic logic [17:0] map_in(input logic [3:0] strap, input logic dc, input logic [17:0] p);
    logic [17:0] r;
    r = p;
    if (!dc) begin
      r = {10'h000, p[7:0]};
    end else begin
      case (strap)
        4'h0: r = {2'h0, p[15:0]};
        4'h1: r = {10'h000, p[7:0]};
        4'h2: r = {2'h0, p[17:10], p[8:1]};
        4'h3: r = {10'h000, p[17:10]};
        4'h9: r = {9'h000, p[8:0]};
        4'hB: r = {9'h000, p[17:9]};
        default: r = p;
      endcase
    end
    return r;
  endfunction : map_in

  // Next-state logic: bus slave, link sequencer, synchronisers
  always_comb begin
    logic tick;
    logic serial;
    logic three_line;
    logic wr_fire;
    logic go;
    logic [31:0] cmd_new;
    logic [31:0] rd_val;
    logic [1:0] rd_resp;
    logic done_set;
    logic done_clr;
    tick = 1'b0;
    serial = 1'b0;
    three_line = 1'b0;
    wr_fire = 1'b0;
    go = 1'b0;
    cmd_new = s.cmd;
    rd_val = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    done_set = 1'b0;
    done_clr = 1'b0;
    next_s = s;

    // Pin inputs pass two flip-flops
    next_s.din_s1 = data_in;
    next_s.din_s2 = s.din_s1;
    next_s.sda_s1 = serial_data_in;
    next_s.sda_s2 = s.sda_s1;

    // Strap decode
    serial = s.ctrl[CTRL_STRAP_LSB + 2];
    three_line = (s.ctrl[CTRL_STRAP_LSB + 3 -: 2] == STRAP_SER3);
    next_s.pins.strap = s.ctrl[CTRL_STRAP_LSB +: 4];
    next_s.pins.reset_n = s.ctrl[CTRL_RESET_REL_BIT];

    // Write address and data taken in either order
    if (s.axi.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
      next_s.axi.awready = 1'b0;
    end
    if (s.axi.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
      next_s.axi.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.axi.bvalid) begin
      wr_fire = 1'b1;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.axi.bvalid = 1'b1;
      next_s.axi.bresp = RESP_OKAY;
      case (s.awaddr)
        ADDR_CTRL: next_s.ctrl = merge_bytes(s.ctrl, s.wdata, s.wstrb);
        ADDR_CMD: begin
          cmd_new = merge_bytes(s.cmd, s.wdata, s.wstrb);
          if (!s.busy) begin
            next_s.cmd = cmd_new;
            go = 1'b1;
          end
        end
        ADDR_STATUS: done_clr = s.wdata[STAT_DONE_BIT] && s.wstrb[0];
        ADDR_RXDATA: ;
        default: next_s.axi.bresp = RESP_SLVERR;
      endcase
    end
    if (s.axi.bvalid && s_axi_bready) begin
      next_s.axi.bvalid = 1'b0;
      next_s.axi.awready = 1'b1;
      next_s.axi.wready = 1'b1;
    end
    if (wr_fire) begin
      next_s.axi.awready = 1'b0;
      next_s.axi.wready = 1'b0;
    end

    // Read channel
    case (s_axi_araddr)
      ADDR_CTRL: rd_val = s.ctrl;
      ADDR_CMD: rd_val = s.cmd;
      ADDR_STATUS: rd_val = {30'h0000_0000, s.done, s.busy};
      ADDR_RXDATA: rd_val = s.rx;
      default: rd_resp = RESP_SLVERR;
    endcase
    if (s.axi.arready && s_axi_arvalid) begin
      next_s.axi.arready = 1'b0;
      next_s.axi.rvalid = 1'b1;
      next_s.axi.rdata = rd_val;
      next_s.axi.rresp = rd_resp;
    end
    if (s.axi.rvalid && s_axi_rready) begin
      next_s.axi.rvalid = 1'b0;
      next_s.axi.arready = 1'b1;
    end

    // Half-period divider, running only during a transfer
    if (s.phase != PH_IDLE) begin
      tick = (s.div == DIV_LAST);
      next_s.div = tick ? 4'h0 : s.div + 4'h1;
    end

    // Link sequencer
    case (s.phase)
      PH_IDLE: begin
        if (go) begin
          next_s.busy = 1'b1;
          next_s.div = 4'h0;
          next_s.rx = 32'h0000_0000;
          next_s.pins.cs_n = 1'b0;
          next_s.pins.dc = cmd_new[CMD_DC_BIT];
          if (!serial) begin
            next_s.pins.data_out = map_out(s.ctrl[CTRL_STRAP_LSB +: 4], cmd_new[CMD_DC_BIT], cmd_new[17:0]);
            next_s.pins.data_oe = !cmd_new[CMD_RD_BIT];
            next_s.pins.wr_n = cmd_new[CMD_RD_BIT];
            next_s.pins.rd_n = !cmd_new[CMD_RD_BIT];
            next_s.phase = PH_P_LOW;
          end else begin
            if (three_line) begin
              next_s.tx = {cmd_new[CMD_DC_BIT], cmd_new[7:0]};
              next_s.bitcnt = SER3_LAST;
            end else begin
              next_s.tx = {cmd_new[7:0], 1'b0};
              next_s.bitcnt = SER4_LAST;
            end
            next_s.pins.sclk = 1'b0;
            next_s.pins.sda_oe = 1'b1;
            next_s.pins.sda_out = three_line ? cmd_new[CMD_DC_BIT] : cmd_new[7];
            next_s.phase = PH_S_LOW;
          end
        end
      end
      PH_P_LOW: begin
        if (tick) begin
          if (!s.pins.rd_n) begin
            next_s.rx = {14'h0000, map_in(s.pins.strap, s.pins.dc, s.din_s2)};
          end
          next_s.pins.wr_n = 1'b1;
          next_s.pins.rd_n = 1'b1;
          next_s.phase = PH_P_HIGH;
        end
      end
      PH_P_HIGH: begin
        if (tick) begin
          next_s.pins.data_oe = 1'b0;
          done_set = 1'b1;
        end
      end
      PH_S_LOW: begin
        if (tick) begin
          next_s.pins.sclk = 1'b1;
          next_s.phase = PH_S_HIGH;
        end
      end
      PH_S_HIGH: begin
        if (tick) begin
          next_s.pins.sclk = 1'b0;
          if (s.bitcnt == 6'h00) begin
            if (s.cmd[CMD_RD_BIT]) begin
              next_s.pins.sda_oe = 1'b0;
              case (s.cmd[CMD_LEN_LSB +: 2])
                2'h1: next_s.bitcnt = RLEN24_LAST;
                2'h2: next_s.bitcnt = RLEN32_LAST;
                default: next_s.bitcnt = RLEN8_LAST;
              endcase
              next_s.phase = PH_R_LOW;
            end else begin
              done_set = 1'b1;
            end
          end else begin
            next_s.tx = {s.tx[7:0], 1'b0};
            next_s.pins.sda_out = s.tx[7];
            next_s.bitcnt = s.bitcnt - 6'h01;
            next_s.phase = PH_S_LOW;
          end
        end
      end
      PH_R_LOW: begin
        if (tick) begin
          next_s.pins.sclk = 1'b1;
          next_s.phase = PH_R_HIGH;
        end
      end
      PH_R_HIGH: begin
        if (tick) begin
          next_s.rx = {s.rx[30:0], s.sda_s2};
          next_s.pins.sclk = 1'b0;
          if (s.bitcnt == 6'h00) begin
            done_set = 1'b1;
          end else begin
            next_s.bitcnt = s.bitcnt - 6'h01;
            next_s.phase = PH_R_LOW;
          end
        end
      end
      default: next_s.phase = PH_IDLE;
    endcase

    // End of transfer: clock parks low, chip select released unless held
    if (done_set) begin
      next_s.busy = 1'b0;
      next_s.phase = PH_IDLE;
      next_s.pins.cs_n = !s.cmd[CMD_KEEP_BIT];
      next_s.pins.sda_oe = 1'b0; // Line let go once the unit is over
    end
    next_s.done = (s.done && !done_clr) || done_set;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.axi.awready <= 1'b1;
      s.axi.wready <= 1'b1;
      s.axi.arready <= 1'b1;
      s.phase <= PH_IDLE;
      s.pins.cs_n <= 1'b1;
      s.pins.wr_n <= 1'b1;
      s.pins.rd_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign s_axi_awready = s.axi.awready;
  assign s_axi_wready = s.axi.wready;
  assign s_axi_bvalid = s.axi.bvalid;
  assign s_axi_bresp = s.axi.bresp;
  assign s_axi_arready = s.axi.arready;
  assign s_axi_rvalid = s.axi.rvalid;
  assign s_axi_rdata = s.axi.rdata;
  assign s_axi_rresp = s.axi.rresp;
  assign interface_strap_pins = s.pins.strap;
  assign external_reset_n = s.pins.reset_n;
  assign chip_select_n = s.pins.cs_n;
  assign write_strobe_n = s.pins.wr_n;
  assign read_strobe_n = s.pins.rd_n;
  assign cmd_data_select = s.pins.dc;
  assign data_out = s.pins.data_out;
  assign data_oe = s.pins.data_oe;
  assign serial_clk = s.pins.sclk;
  assign serial_data_out = s.pins.sda_out;
  assign serial_data_oe = s.pins.sda_oe;

endmodule : lcd_host_ctrl

// ==== testbench/lcd_host_ctrl_monitor.sv ====
// Pin protocol checker for the LCD host-port controller
`timescale 1ns/100ps
module lcd_host_ctrl_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Display driver pins
  input wire logic [3:0] interface_strap_pins,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [17:0] data_out,
  input wire logic data_oe,
  input wire logic serial_clk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Strap pins never move inside a selected transfer
  strap_hold_a: assert property (!chip_select_n |-> $stable(interface_strap_pins))
    else $error("strap pins changed while selected");
  // Write strobe pulses only inside a selected cycle
  wr_select_a: assert property (!write_strobe_n |-> !chip_select_n)
    else $error("write strobe low without chip select");
  // Write strobe low for a half period, then high for a half period
  wr_pulse_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n [*4])
    else $error("write strobe pulse width wrong");
  // Bus driven and held through the rising strobe edge
  wr_data_a: assert property (!write_strobe_n |=> data_oe && $stable(data_out))
    else $error("write data not held past strobe");
  // Strobes exclusive, and bus released while reading
  rd_release_a: assert property (!read_strobe_n |-> write_strobe_n && !data_oe)
    else $error("bus driven or write strobe low during read");
  // Select falls a full half period before the first serial clock
  cs_first_a: assert property ($fell(chip_select_n) && interface_strap_pins[2] |-> !serial_clk [*4] ##1 serial_clk)
    else $error("serial clock too early after select");
  // Serial clock high phase lasts a half period
  sclk_high_a: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
    else $error("serial clock high phase wrong");
  // Host serial data holds while the clock stays high
  sda_hold_a: assert property (serial_clk && $past(serial_clk) |-> $stable(serial_data_out))
    else $error("serial data changed while clock high");
  // Host releases the data line only with the clock low
  sda_release_a: assert property ($fell(serial_data_oe) |-> !serial_clk && !chip_select_n || chip_select_n)
    else $error("serial line released with clock high");
endmodule : lcd_host_ctrl_monitor

bind lcd_host_ctrl lcd_host_ctrl_monitor u_lcd_host_ctrl_monitor (.aclk, .aresetn, .interface_strap_pins,
  .chip_select_n, .write_strobe_n, .read_strobe_n, .data_out, .data_oe, .serial_clk, .serial_data_out,
  .serial_data_oe);

// ==== testbench/lcd_device_model.sv ====
// Behavioural display driver facing the host controller pins
`timescale 1ns/100ps
module lcd_device_model #(
  parameter logic [7:0] ID_READ_CODE = 8'h04,
  parameter logic [7:0] STAT_READ_CODE = 8'h09,
  parameter logic [7:0] FMT_CMD_CODE = 8'h3A,
  parameter int FMT_LSB = 0
) (
  // Host-driven pins
  input wire logic [3:0] strap,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic dc,
  input wire logic [17:0] bus,
  input wire logic sclk,
  input wire logic sda,
  // Response content
  input wire logic [31:0] resp,
  // Device drive onto shared lines
  output logic [17:0] dev_bus,
  output logic dev_bus_oe,
  output logic dev_sda,
  output logic dev_sda_oe,
  // Last unit received
  output logic [17:0] cap_word,
  output logic cap_dc,
  output logic [7:0] cap_count,
  // Pixel format field last set by the host
  output logic [2:0] host_pixel_format_field
);
  logic [8:0] sh;
  logic [31:0] rsh;
  logic flag;
  int nbits;
  int rleft;
  logic fmt_armed;
  initial begin
    cap_count = 8'h00;
    fmt_armed = 1'b0;
    host_pixel_format_field = 3'h0;
    nbits = 0;
    rleft = 0;
    dev_sda = 1'b0;
    dev_sda_oe = 1'b0;
  end
  // Parallel capture on the write strobe rising edge, only while selected
  always @(posedge wr_n) begin
    if (!cs_n && !strap[2] && rd_n) begin
      cap_word <= bus;
      cap_dc <= dc;
      cap_count <= cap_count + 8'h01;
    end
  end
  // Read data only in data phase; otherwise the bus is left floating
  assign dev_bus_oe = !cs_n && !rd_n && dc && !strap[2];
  assign dev_bus = resp[17:0];
  // Acts only on whole units: the format parameter follows its command
  always @(cap_count) begin
    if (!cap_dc) begin
      fmt_armed = (cap_word[7:0] == FMT_CMD_CODE);
    end else if (fmt_armed) begin
      host_pixel_format_field = cap_word[FMT_LSB +: 3];
      fmt_armed = 1'b0;
    end
  end
  // Deselect drops partial bits and restarts the serial interface
  always @(posedge cs_n) begin
    nbits = 0;
    rleft = 0;
    dev_sda_oe = 1'b0;
  end
  // Serial bits sampled on rising clock edges, MSB first, clock may stop
  always @(posedge sclk) begin
    // No input sampling while the last response bit still stands
    if (!cs_n && strap[2] && rleft == 0 && !dev_sda_oe) begin
      sh = {sh[7:0], sda};
      nbits = nbits + 1;
      if (nbits == (strap[3] ? 8 : 9)) begin
        nbits = 0;
        flag = strap[3] ? dc : sh[8];
        cap_word = {10'h000, sh[7:0]};
        cap_dc = flag;
        cap_count = cap_count + 8'h01;
        if (!flag) begin
          rleft = (sh[7:0] == ID_READ_CODE) ? 24 : (sh[7:0] == STAT_READ_CODE) ? 32 : 0;
          rleft = (sh[7:0] >= 8'h0A && sh[7:0] <= 8'h0F) ? 8 : rleft;
          rsh = resp << (32 - rleft);
        end
      end
    end
  end
  // Response bits shifted out on falling edges on the same line
  always @(negedge sclk) begin
    if (rleft > 0 && !cs_n) begin
      dev_sda = rsh[31];
      rsh = rsh << 1;
      dev_sda_oe = 1'b1;
      rleft = rleft - 1;
    end else begin
      dev_sda_oe = 1'b0;
    end
  end
endmodule : lcd_device_model

// ==== testbench/test_lcd_host_ctrl.sv ====
// Self-checking testbench for the LCD host-port controller
`timescale 1ns/100ps
module test_lcd_host_ctrl;
  import lcd_host_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, resp, rd_v;
  logic [3:0] s_axi_wstrb, interface_strap_pins;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, external_reset_n;
  logic chip_select_n, write_strobe_n, read_strobe_n, cmd_data_select, data_oe, serial_clk;
  logic serial_data_out, serial_data_oe, dev_bus_oe, dev_sda, dev_sda_oe, cap_dc, last_sda, serial_data_in;
  logic [17:0] data_out, data_in, dev_bus, cap_word, last_bus;
  logic [7:0] cap_count;
  logic [2:0] pix_fmt;
  logic [7:0] codes [3] = '{8'h0A, 8'h04, 8'h09};
  logic [31:0] masks [3] = '{32'h0000_00FF, 32'h00FF_FFFF, 32'hFFFF_FFFF};
  int err_count = 0;
  int n_compared = 0;

  lcd_host_ctrl u_lcd_host_ctrl (.*);
  lcd_device_model #(.ID_READ_CODE(8'h04), .STAT_READ_CODE(8'h09)) u_lcd_device_model (
    .strap(interface_strap_pins), .cs_n(chip_select_n), .wr_n(write_strobe_n), .rd_n(read_strobe_n),
    .dc(cmd_data_select), .bus(data_in), .sclk(serial_clk), .sda(serial_data_in), .resp, .dev_bus,
    .dev_bus_oe, .dev_sda, .dev_sda_oe, .cap_word, .cap_dc, .cap_count, .host_pixel_format_field(pix_fmt));

  always #10 aclk = ~aclk;
  // Shared lines: the enabled party drives, else a level that keeps changing
  assign data_in = data_oe ? data_out : dev_bus_oe ? dev_bus : ~last_bus;
  assign serial_data_in = serial_data_oe ? serial_data_out : dev_sda_oe ? dev_sda : ~last_sda;
  always @(posedge aclk) begin
    last_bus <= data_in;
    last_sda <= serial_data_in;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  // Start one link transfer and poll until the controller is idle
  task automatic xfer(input logic [17:0] w, input logic d, input logic r, input logic [1:0] len, input logic k);
    logic [31:0] st;
    axi_write(ADDR_CMD, 32'(w) | 32'(d) << CMD_DC_BIT | 32'(r) << CMD_RD_BIT | 32'(len) << CMD_LEN_LSB
      | 32'(k) << CMD_KEEP_BIT, rs);
    do axi_read(ADDR_STATUS, st, rs);
    while (st[STAT_BUSY_BIT] !== 1'b0);
  endtask : xfer

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Watchdog well beyond the expected run of about 2000 cycles
  initial begin
    #1_000_000;
    err_count++;
    complete_run();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, resp, last_bus, last_sda} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and unmapped address
    axi_read(ADDR_CTRL, rd_v, rs);
    check("ctrl", CTRL_RST, rd_v);
    check("ctrl resp", 32'(RESP_OKAY), 32'(rs));
    check("cs idle", 32'h1, 32'(chip_select_n));
    axi_read(32'h0000_0010, rd_v, rs);
    check("bad read", 32'(RESP_SLVERR), 32'(rs));
    axi_write(32'h0000_0010, 32'h1, rs);
    check("bad write", 32'(RESP_SLVERR), 32'(rs));
    $display("test reset done");
    // 16-bit parallel: command kept selected, then data word, done flag
    axi_write(ADDR_CTRL, 32'h10, rs);
    check("ctrl wr resp", 32'(RESP_OKAY), 32'(rs));
    check("ext reset", 32'h1, 32'(external_reset_n));
    xfer(18'h0002C, 1'b0, 1'b0, 2'h0, 1'b1);
    check("cmd byte", 32'h2C, 32'(cap_word[7:0]));
    check("cmd flag", 32'h0, 32'(cap_dc));
    check("held select", 32'h0, 32'(chip_select_n));
    xfer(18'h0ABCD, 1'b1, 1'b0, 2'h0, 1'b0);
    check("data word", 32'hABCD, 32'(cap_word[15:0]));
    check("units", 32'h2, 32'(cap_count));
    xfer(18'h0003A, 1'b0, 1'b0, 2'h0, 1'b0);
    xfer(18'h00005, 1'b1, 1'b0, 2'h0, 1'b0);
    check("pixel format", 32'h5, 32'(pix_fmt));
    axi_read(ADDR_STATUS, rd_v, rs);
    check("done", 32'h1, 32'(rd_v[STAT_DONE_BIT]));
    axi_write(ADDR_STATUS, 32'h2, rs);
    axi_read(ADDR_STATUS, rd_v, rs);
    check("done clr", 32'h0, rd_v);
    $display("test parallel16 done");
    // 18-bit parallel: full word write, then data read
    axi_write(ADDR_CTRL, 32'h18, rs);
    check("strap", 32'h8, 32'(interface_strap_pins));
    xfer(18'h3A5C3, 1'b1, 1'b0, 2'h0, 1'b0);
    check("wide word", 32'h3A5C3, 32'(cap_word));
    resp = 32'h0002_B4D1;
    xfer(18'h00000, 1'b1, 1'b1, 2'h0, 1'b0);
    axi_read(ADDR_RXDATA, rd_v, rs);
    check("par read", 32'h2_B4D1, rd_v);
    $display("test parallel18 done");
    // Serial 3-line then 4-line: command and parameter, then three read lengths
    resp = 32'h89AB_CDEF;
    for (int m = 0; m < 2; m++) begin
      axi_write(ADDR_CTRL, m ? 32'h1C : 32'h14, rs);
      for (int d = 0; d < 2; d++) begin
        xfer(d ? 18'h0004B : 18'h000B4, 1'(d), 1'b0, 2'h0, 1'b0);
        check("ser byte", d ? 32'h4B : 32'hB4, 32'(cap_word));
        check("ser flag", 32'(d), 32'(cap_dc));
      end
      for (int k = 0; k < 3; k++) begin
        xfer(18'(codes[k]), 1'b0, 1'b1, 2'(k), 1'b0);
        axi_read(ADDR_RXDATA, rd_v, rs);
        check("ser read", resp & masks[k], rd_v);
      end
      $display("test serial mode %0d done", m);
    end
    complete_run();
  end
endmodule : test_lcd_host_ctrl
